/* design/clk_switch_pkg.sv */
// Constants and types for the CPU clock source switch controller.
// Assumes the device register port answers each access with sfr_ack.
// Overview of operation
// - HS to internal: start osc, 10us, clear select
// - HS to sub: pin mode, start, wait, select
// - Skip sub setup when already on sub
// - Sub to internal: start osc, main, cpu select
// - Skip osc start when already running
// - Skip main select write when already right
// - Sub to HS: stab, start, flash, main, cpu
// - Stab select not shorter than awaited time
// - Flash fast bit set above 10 MHz
// - Flash bit may stay clear when divided
// - Skip HS setup when HS already running
// - Skip register writes already holding value; STOP on crystal still rewrites stab select
// - HALT entered by instruction from any source
// - Before STOP on crystal, program stab select
package clk_switch_pkg;

	// ************************************************
	// Register addresses and fields
	// ************************************************
	localparam logic [7:0] ADDR_CMC  = 8'h00;
	localparam logic [7:0] ADDR_CSC  = 8'h01;
	localparam logic [7:0] ADDR_OSC_STAB_TIME_STATUS = 8'h02;
	localparam logic [7:0] ADDR_OSC_STAB_TIME_SELECT = 8'h03;
	localparam logic [7:0] ADDR_CKC  = 8'h04;
	localparam logic [7:0] ADDR_OPERATION_SPEED_MODE_REG = 8'h05;

	localparam int CMC_EXT_POS  = 7;
	localparam int CMC_MAIN_POS = 6;
	localparam int CMC_SUB_POS  = 4;
	localparam int CMC_AMP_POS  = 0;
	localparam int CSC_MAIN_OSC_STOP_POS = 7;
	localparam int CSC_XSTOP_POS = 6;
	localparam int CSC_ISTOP_POS = 0;
	localparam int CKC_CLS_POS = 7;
	localparam int CKC_CSS_POS = 6;
	localparam int CKC_MCS_POS = 5;
	localparam int CKC_MCM_POS = 4;
	localparam int OPERATION_SPEED_MODE_REG_FLASH_HIGH_SPEED_SELECT_POS = 0;

	localparam logic [7:0] CSC_RESET = 8'hc0;

	// ************************************************
	// Timing
	// ************************************************
	localparam int CLK_MHZ      = 10;
	localparam int ACC_STAB_US  = 10;
	localparam int ACC_STAB_CYC = ACC_STAB_US * CLK_MHZ;
	localparam int SUB_STAB_US  = 1000;
	localparam logic [7:0] ACC_CNT_MAX = 8'hff;

	// ************************************************
	// Types
	// ************************************************
	typedef enum logic [2:0] {
		TGT_INT, TGT_HS, TGT_SUB, TGT_HALT, TGT_STOP
	} target_t;

	typedef struct packed {
		target_t    target;
		logic       ext_clock;
		logic       xtal_fast;
		logic       flash_fast;
		logic       main_en;
		logic       sub_en;
		logic [2:0] stab_sel;
		logic [7:0] stab_need;
	} cmd_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
		logic       byte8;
	} sfr_req_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_RD_CKC, ST_CMC, ST_OSC_STAB_TIME_SELECT, ST_CSC, ST_OPERATION_SPEED_MODE_REG, ST_WAIT,
		ST_OSC_STAB_TIME_STATUS, ST_MCM, ST_CSS, ST_POLL, ST_HALT, ST_STOP, ST_DONE
	} state_t;

	localparam int NST = 14;

	typedef struct packed {
		state_t     st;
		sfr_req_t   req;
		cmd_t       cmd;
		logic [7:0] clock_run_control_reg;
		logic       cpu_clock_select;
		logic       mcm;
		logic       cpu_source_status;
		logic       main_source_status;
		logic       cmc_done;
		logic       ext_q;
		logic       operation_speed_mode_reg_done;
		logic       osc_stab_time_select_ok;
		logic [2:0] osc_stab_time_select_q;
		logic       started;
		logic       tmr_start;
		logic       ready;
		logic       done;
		logic       halt;
		logic       stop;
	} ctl_t;

endpackage

/* design/stab_timer.sv */
// Down counter for fixed settling waits.
// Assumes start is a one-cycle pulse and load is stable with it.
`timescale 1ns/10ps
module stab_timer (
	input  wire logic        clk_sys, // System clock
	input  wire logic        rst_n,   // Async reset, active low
	input  wire logic        start,   // Load pulse
	input  wire logic [15:0] load,    // Cycles to wait
	output logic             done     // One-cycle end pulse
);

	typedef struct packed {
		logic [15:0] cnt;
		logic        run;
		logic        done;
	} tmr_t;

	tmr_t t_q;
	tmr_t t_d;

	always_comb begin
		t_d = t_q;
		t_d.done = 1'b0;
		if (start) begin
			t_d.cnt = load;
			t_d.run = 1'b1;
		end else if (t_q.run) begin
			if (t_q.cnt <= 16'h0001) begin
				t_d.run = 1'b0;
				t_d.done = 1'b1;
			end else begin
				t_d.cnt = t_q.cnt - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			t_q <= '0;
		end else begin
			t_q <= t_d;
		end
	end

	assign done = t_q.done;

endmodule

/* design/clk_switch_ctrl.sv */
// Host sequencer that switches the device CPU clock source.
// Assumes the device answers every register access with sfr_ack.
`timescale 1ns/10ps
module clk_switch_ctrl #(
	parameter int SUB_STAB_US = clk_switch_pkg::SUB_STAB_US
) (
	input  wire logic                      clk_sys,    // 10 MHz clock
	input  wire logic                      rst_n,      // Async reset
	input  wire logic                      cmd_valid,  // Order present
	input  wire clk_switch_pkg::cmd_t      cmd,        // Order fields
	input  wire logic                      sfr_ack,    // Access done
	input  wire logic [7:0]                sfr_rdata,  // Read data
	output clk_switch_pkg::sfr_req_t       sfr_req,    // Register access
	output logic                           halt_exec,  // HALT pulse
	output logic                           stop_exec,  // STOP pulse
	output logic                           cmd_ready,  // Idle
	output logic                           cmd_done,   // Order finished
	output logic                           cpu_on_sub, // Last CPU status
	output logic                           main_on_hs  // Last main status
);

	localparam int SUB_CYC = SUB_STAB_US * clk_switch_pkg::CLK_MHZ;
	localparam logic [15:0] SUB_LOAD = 16'(SUB_CYC);
	localparam logic [15:0] ACC_LOAD = 16'(clk_switch_pkg::ACC_STAB_CYC);

	clk_switch_pkg::ctl_t s;
	clk_switch_pkg::ctl_t n;
	logic tmr_done;

	// ************************************************
	// Helpers
	// ************************************************
	function automatic logic is_wr(clk_switch_pkg::sfr_req_t r,
			logic ack, logic [7:0] a);
		return r.wr && ack && (r.addr == a);
	endfunction

	function automatic logic status_ok(clk_switch_pkg::ctl_t x);
		logic ok;
		ok = 1'b1;
		case (x.cmd.target)
			clk_switch_pkg::TGT_INT: ok = !x.cpu_source_status && !x.main_source_status;
			clk_switch_pkg::TGT_HS:  ok = !x.cpu_source_status && x.main_source_status;
			clk_switch_pkg::TGT_SUB: ok = x.cpu_source_status;
			default:                 ok = 1'b1;
		endcase
		return ok;
	endfunction

	// Which steps the current order still needs
	function automatic logic [clk_switch_pkg::NST-1:0] need_of(
			clk_switch_pkg::ctl_t x);
		logic [clk_switch_pkg::NST-1:0] nd;
		logic hs;
		logic sub;
		logic int_t;
		logic hs_set;
		logic sub_set;
		hs = x.cmd.target == clk_switch_pkg::TGT_HS;
		sub = x.cmd.target == clk_switch_pkg::TGT_SUB;
		int_t = x.cmd.target == clk_switch_pkg::TGT_INT;
		// Setup stays wanted once this order has started the oscillator
		hs_set = hs && (x.clock_run_control_reg[clk_switch_pkg::CSC_MAIN_OSC_STOP_POS] ||
			x.started);
		sub_set = sub && !x.cpu_source_status;
		nd = '0;
		nd[clk_switch_pkg::ST_CMC] = !x.cmc_done && (hs_set || sub_set);
		nd[clk_switch_pkg::ST_OSC_STAB_TIME_SELECT] =
			(hs_set && !(x.osc_stab_time_select_ok && x.osc_stab_time_select_q == x.cmd.stab_sel)) ||
			(x.cmd.target == clk_switch_pkg::TGT_STOP && x.main_source_status &&
			 !x.cpu_source_status && !x.ext_q);
		nd[clk_switch_pkg::ST_CSC] =
			(int_t && x.clock_run_control_reg[clk_switch_pkg::CSC_ISTOP_POS]) ||
			hs_set ||
			(sub_set && x.clock_run_control_reg[clk_switch_pkg::CSC_XSTOP_POS]);
		nd[clk_switch_pkg::ST_OPERATION_SPEED_MODE_REG] = hs_set && !x.operation_speed_mode_reg_done;
		nd[clk_switch_pkg::ST_WAIT] = (int_t && !x.cpu_source_status && x.mcm) ||
			(x.started && sub);
		nd[clk_switch_pkg::ST_OSC_STAB_TIME_STATUS] = hs_set && !x.ext_q;
		nd[clk_switch_pkg::ST_MCM] = (int_t && x.mcm) ||
			(hs && !x.mcm);
		nd[clk_switch_pkg::ST_CSS] = ((int_t || hs) && x.cpu_clock_select) ||
			(sub && !x.cpu_clock_select);
		nd[clk_switch_pkg::ST_POLL] = int_t || hs || sub;
		nd[clk_switch_pkg::ST_HALT] =
			x.cmd.target == clk_switch_pkg::TGT_HALT;
		nd[clk_switch_pkg::ST_STOP] =
			x.cmd.target == clk_switch_pkg::TGT_STOP;
		nd[clk_switch_pkg::ST_DONE] = 1'b1;
		return nd;
	endfunction

	function automatic clk_switch_pkg::state_t step_after(
			clk_switch_pkg::state_t cur,
			logic [clk_switch_pkg::NST-1:0] nd);
		clk_switch_pkg::state_t r;
		r = clk_switch_pkg::ST_DONE;
		for (int i = clk_switch_pkg::NST - 1; i >= 0; i--) begin
			if (i > int'(cur) && nd[i]) begin
				r = clk_switch_pkg::state_t'(i);
			end
		end
		return r;
	endfunction

	// Register access issued on entry to a step
	function automatic clk_switch_pkg::sfr_req_t req_for(
			clk_switch_pkg::state_t st, clk_switch_pkg::ctl_t x);
		clk_switch_pkg::sfr_req_t r;
		logic [7:0] v;
		r = '0;
		v = 8'h00;
		case (st)
			clk_switch_pkg::ST_RD_CKC, clk_switch_pkg::ST_POLL: begin
				r.addr = clk_switch_pkg::ADDR_CKC;
				r.rd = 1'b1;
			end
			clk_switch_pkg::ST_OSC_STAB_TIME_STATUS: begin
				r.addr = clk_switch_pkg::ADDR_OSC_STAB_TIME_STATUS;
				r.rd = 1'b1;
			end
			clk_switch_pkg::ST_CMC: begin
				v[clk_switch_pkg::CMC_EXT_POS] = x.cmd.ext_clock;
				v[clk_switch_pkg::CMC_MAIN_POS] = x.cmd.main_en ||
					x.cmd.target == clk_switch_pkg::TGT_HS;
				v[clk_switch_pkg::CMC_SUB_POS] = x.cmd.sub_en ||
					x.cmd.target == clk_switch_pkg::TGT_SUB;
				v[clk_switch_pkg::CMC_AMP_POS] = x.cmd.xtal_fast;
				r.addr = clk_switch_pkg::ADDR_CMC;
			end
			clk_switch_pkg::ST_OSC_STAB_TIME_SELECT: begin
				v[2:0] = x.cmd.stab_sel;
				r.addr = clk_switch_pkg::ADDR_OSC_STAB_TIME_SELECT;
			end
			clk_switch_pkg::ST_CSC: begin
				v = x.clock_run_control_reg;
				case (x.cmd.target)
					clk_switch_pkg::TGT_INT:
						v[clk_switch_pkg::CSC_ISTOP_POS] = 1'b0;
					clk_switch_pkg::TGT_HS:
						v[clk_switch_pkg::CSC_MAIN_OSC_STOP_POS] = 1'b0;
					default:
						v[clk_switch_pkg::CSC_XSTOP_POS] = 1'b0;
				endcase
				r.addr = clk_switch_pkg::ADDR_CSC;
			end
			clk_switch_pkg::ST_OPERATION_SPEED_MODE_REG: begin
				v[clk_switch_pkg::OPERATION_SPEED_MODE_REG_FLASH_HIGH_SPEED_SELECT_POS] =
					x.cmd.flash_fast;
				r.addr = clk_switch_pkg::ADDR_OPERATION_SPEED_MODE_REG;
			end
			clk_switch_pkg::ST_MCM, clk_switch_pkg::ST_CSS: begin
				v[clk_switch_pkg::CKC_CSS_POS] = x.cpu_clock_select;
				v[clk_switch_pkg::CKC_MCM_POS] = x.mcm;
				if (st == clk_switch_pkg::ST_MCM) begin
					v[clk_switch_pkg::CKC_MCM_POS] =
						x.cmd.target == clk_switch_pkg::TGT_HS;
				end else begin
					v[clk_switch_pkg::CKC_CSS_POS] =
						x.cmd.target == clk_switch_pkg::TGT_SUB;
				end
				r.addr = clk_switch_pkg::ADDR_CKC;
			end
			default: r = '0;
		endcase
		if (r.addr != 8'h00 || st == clk_switch_pkg::ST_CMC) begin
			r.wr = !r.rd;
		end
		r.wdata = v;
		r.byte8 = r.wr;
		return r;
	endfunction

	// ************************************************
	// Sequencer
	// ************************************************
	always_comb begin
		n = s;
		n.done = 1'b0;
		n.halt = 1'b0;
		n.stop = 1'b0;
		n.tmr_start = 1'b0;
		case (s.st)
			clk_switch_pkg::ST_IDLE: begin
				if (cmd_valid) begin
					n.cmd = cmd;
					n.ready = 1'b0;
					n.started = 1'b0;
					n.st = clk_switch_pkg::ST_RD_CKC;
					n.req = req_for(clk_switch_pkg::ST_RD_CKC, n);
				end
			end
			clk_switch_pkg::ST_DONE: begin
				n.st = clk_switch_pkg::ST_IDLE;
				n.ready = 1'b1;
				n.done = 1'b1;
			end
			default: begin
				if ((s.st == clk_switch_pkg::ST_WAIT && tmr_done) ||
				    s.st == clk_switch_pkg::ST_HALT ||
				    s.st == clk_switch_pkg::ST_STOP ||
				    ((s.req.wr || s.req.rd) && sfr_ack)) begin
					n.req = '0;
					case (s.st)
						clk_switch_pkg::ST_RD_CKC: begin
							n.cpu_clock_select = sfr_rdata[clk_switch_pkg::CKC_CSS_POS];
							n.mcm = sfr_rdata[clk_switch_pkg::CKC_MCM_POS];
						end
						clk_switch_pkg::ST_CMC: begin
							n.cmc_done = 1'b1;
							n.ext_q = s.cmd.ext_clock;
						end
						clk_switch_pkg::ST_OSC_STAB_TIME_SELECT: begin
							n.osc_stab_time_select_ok = 1'b1;
							n.osc_stab_time_select_q = s.cmd.stab_sel;
						end
						clk_switch_pkg::ST_CSC: begin
							n.clock_run_control_reg = s.req.wdata;
							n.started = 1'b1;
						end
						clk_switch_pkg::ST_OPERATION_SPEED_MODE_REG: n.operation_speed_mode_reg_done = 1'b1;
						clk_switch_pkg::ST_MCM:
							n.mcm = s.req.wdata[clk_switch_pkg::CKC_MCM_POS];
						clk_switch_pkg::ST_CSS:
							n.cpu_clock_select = s.req.wdata[clk_switch_pkg::CKC_CSS_POS];
						default: n.req = '0;
					endcase
					if (s.st == clk_switch_pkg::ST_RD_CKC ||
					    s.st == clk_switch_pkg::ST_POLL) begin
						n.cpu_source_status = sfr_rdata[clk_switch_pkg::CKC_CLS_POS];
						n.main_source_status = sfr_rdata[clk_switch_pkg::CKC_MCS_POS];
					end
					n.st = step_after(s.st, need_of(n));
					// Keep reading until the counter or status catches up
					if ((s.st == clk_switch_pkg::ST_OSC_STAB_TIME_STATUS &&
					     sfr_rdata < s.cmd.stab_need) ||
					    (s.st == clk_switch_pkg::ST_POLL &&
					     !status_ok(n))) begin
						n.st = s.st;
					end
					n.req = req_for(n.st, n);
					n.tmr_start = n.st == clk_switch_pkg::ST_WAIT;
					n.halt = n.st == clk_switch_pkg::ST_HALT;
					n.stop = n.st == clk_switch_pkg::ST_STOP;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.clock_run_control_reg <= clk_switch_pkg::CSC_RESET;
			s.ready <= 1'b1;
		end else begin
			s <= n;
		end
	end

	stab_timer u_timer (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.start   (s.tmr_start),
		.load    (s.cmd.target == clk_switch_pkg::TGT_SUB ?
		          SUB_LOAD : ACC_LOAD),
		.done    (tmr_done)
	);

	assign sfr_req = s.req;
	assign halt_exec = s.halt;
	assign stop_exec = s.stop;
	assign cmd_ready = s.ready;
	assign cmd_done = s.done;
	assign cpu_on_sub = s.cpu_source_status;
	assign main_on_hs = s.main_source_status;

	// ************************************************
	// Assertions
	// ************************************************
	logic [7:0] acc_cnt;
	localparam int ACC_MIN = clk_switch_pkg::ACC_STAB_CYC;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			acc_cnt <= 8'h00;
		end else if (is_wr(s.req, sfr_ack, clk_switch_pkg::ADDR_CSC) ||
		             (s.st == clk_switch_pkg::ST_IDLE && cmd_valid)) begin
			acc_cnt <= 8'h00;
		end else if (acc_cnt != clk_switch_pkg::ACC_CNT_MAX) begin
			acc_cnt <= acc_cnt + 8'h01;
		end
	end

	property p_int_wait;
		@(posedge clk_sys) disable iff (!rst_n)
		is_wr(s.req, sfr_ack, clk_switch_pkg::ADDR_CKC) &&
		!s.req.wdata[clk_switch_pkg::CKC_MCM_POS] && s.mcm &&
		s.cmd.target == clk_switch_pkg::TGT_INT && !s.cpu_source_status
		|-> acc_cnt >= ACC_MIN;
	endproperty
	a_int_wait: assert property (p_int_wait)
		else $error("main select cleared before 10 us settle");

	property p_cmc_once;
		@(posedge clk_sys) disable iff (!rst_n)
		is_wr(s.req, sfr_ack, clk_switch_pkg::ADDR_CMC)
		|-> !s.cmc_done && s.req.byte8 ##1 s.cmc_done;
	endproperty
	a_cmc_once: assert property (p_cmc_once)
		else $error("mode register written twice");

	property p_sub_css;
		@(posedge clk_sys) disable iff (!rst_n)
		is_wr(s.req, sfr_ack, clk_switch_pkg::ADDR_CKC) &&
		s.req.wdata[clk_switch_pkg::CKC_CSS_POS] && !s.cpu_clock_select
		|-> !s.clock_run_control_reg[clk_switch_pkg::CSC_XSTOP_POS] && s.cmc_done;
	endproperty
	a_sub_css: assert property (p_sub_css)
		else $error("sub select before sub oscillator start");

	property p_osc_stab_time_status_ext;
		@(posedge clk_sys) disable iff (!rst_n)
		s.req.rd && s.req.addr == clk_switch_pkg::ADDR_OSC_STAB_TIME_STATUS |-> !s.ext_q;
	endproperty
	a_osc_stab_time_status_ext: assert property (p_osc_stab_time_status_ext)
		else $error("stab counter polled with external clock");

	property p_flash_high_speed_select;
		@(posedge clk_sys) disable iff (!rst_n)
		is_wr(s.req, sfr_ack, clk_switch_pkg::ADDR_OPERATION_SPEED_MODE_REG)
		|-> s.req.wdata[clk_switch_pkg::OPERATION_SPEED_MODE_REG_FLASH_HIGH_SPEED_SELECT_POS] == s.cmd.flash_fast;
	endproperty
	a_flash_high_speed_select: assert property (p_flash_high_speed_select)
		else $error("flash speed bit differs from order");

	property p_hs_order;
		@(posedge clk_sys) disable iff (!rst_n)
		is_wr(s.req, sfr_ack, clk_switch_pkg::ADDR_CKC) &&
		s.cmd.target == clk_switch_pkg::TGT_HS
		|-> !s.clock_run_control_reg[clk_switch_pkg::CSC_MAIN_OSC_STOP_POS] &&
		(s.req.wdata[clk_switch_pkg::CKC_MCM_POS] ||
		 s.req.wdata[clk_switch_pkg::CKC_CSS_POS]);
	endproperty
	a_hs_order: assert property (p_hs_order)
		else $error("high-speed select before oscillator start");

	property p_halt;
		@(posedge clk_sys) disable iff (!rst_n)
		halt_exec |-> s.cmd.target == clk_switch_pkg::TGT_HALT
		##1 !halt_exec ##1 cmd_done;
	endproperty
	a_halt: assert property (p_halt)
		else $error("halt pulse malformed");

	property p_stop_osc_stab_time_select;
		@(posedge clk_sys) disable iff (!rst_n)
		stop_exec && s.main_source_status && !s.cpu_source_status && !s.ext_q |-> s.osc_stab_time_select_ok;
	endproperty
	a_stop_osc_stab_time_select: assert property (p_stop_osc_stab_time_select)
		else $error("stop on crystal without stab select");

	property p_done_match;
		@(posedge clk_sys) disable iff (!rst_n)
		cmd_done |-> status_ok(s);
	endproperty
	a_done_match: assert property (p_done_match)
		else $error("order finished before status matched");

	c_to_sub: cover property (@(posedge clk_sys) disable iff (!rst_n)
		cmd_done && s.cmd.target == clk_switch_pkg::TGT_SUB);
	c_to_hs: cover property (@(posedge clk_sys) disable iff (!rst_n)
		cmd_done && s.cmd.target == clk_switch_pkg::TGT_HS);
	c_to_int: cover property (@(posedge clk_sys) disable iff (!rst_n)
		cmd_done && s.cmd.target == clk_switch_pkg::TGT_INT && s.started);
	c_stop: cover property (@(posedge clk_sys) disable iff (!rst_n)
		stop_exec);

endmodule

/* verification/clock_device_model.sv */
// Behavioural model of the device clock registers behind the host port.
// Assumes one access at a time from the host, held until sfr_ack.
`timescale 1ns/10ps
module clock_device_model #(
	parameter int SW_DLY = 4 // Clocks on the old source after a SYSTEM_CLOCK_CONTROL_REG write
) (
	input  wire logic                     clk_sys,   // System clock
	input  wire logic                     rst_n,     // Async reset
	input  wire clk_switch_pkg::sfr_req_t req,       // Host access
	input  wire logic [1:0]               lat,       // Extra ack wait
	input  wire logic                     halt_exec, // HALT pulse
	input  wire logic                     stop_exec, // STOP pulse
	output logic                          sfr_ack,   // Access done
	output logic [7:0]                    sfr_rdata  // Read data
);
	// ****************
	// State and write log
	// ****************
	logic [7:0] cmc_q, csc_q, osc_stab_time_select_q, osc_stab_time_status_q, operation_speed_mode_reg_q, rd_q;
	logic       cmc_lk_q, operation_speed_mode_reg_lk_q, css_q, mcm_q, cls_q, mcs_q, ack_q;
	logic [1:0] cnt_q;
	int         sw_n, cyc, log_n, halt_n, stop_n, stop_cyc;
	logic [7:0] log_a [64];
	logic [7:0] log_d [64];
	logic [7:0] log_s [64];
	int         log_c [64];

	// Released bus shows the inverse, never a stale copy
	assign sfr_ack   = ack_q;
	assign sfr_rdata = ack_q ? rd_q : ~rd_q;

	function automatic logic [7:0] rd_val(input logic [7:0] a);
		case (a)
			clk_switch_pkg::ADDR_CMC:  return cmc_q;
			clk_switch_pkg::ADDR_CSC:  return csc_q;
			clk_switch_pkg::ADDR_OSC_STAB_TIME_STATUS: return osc_stab_time_status_q;
			clk_switch_pkg::ADDR_OSC_STAB_TIME_SELECT: return osc_stab_time_select_q;
			clk_switch_pkg::ADDR_CKC:  return {cls_q, css_q, mcs_q, mcm_q, 4'h0};
			clk_switch_pkg::ADDR_OPERATION_SPEED_MODE_REG: return operation_speed_mode_reg_q;
			default:                   return 8'h00;
		endcase
	endfunction

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			{cmc_q, osc_stab_time_select_q, osc_stab_time_status_q, operation_speed_mode_reg_q, rd_q} <= '0;
			{cmc_lk_q, operation_speed_mode_reg_lk_q, css_q, mcm_q, cls_q, mcs_q, ack_q} <= '0;
			csc_q <= clk_switch_pkg::CSC_RESET;
			cnt_q <= 2'b00;
			{sw_n, cyc, log_n, halt_n, stop_n, stop_cyc} <= '0;
		end else begin
			cyc <= cyc + 1;
			if (!csc_q[7] && osc_stab_time_status_q != 8'hff)
				osc_stab_time_status_q <= osc_stab_time_status_q + 8'h01;
			// Status follows the select bits only after a delay
			if (sw_n == 1) begin
				cls_q <= css_q;
				mcs_q <= mcm_q;
			end
			if (sw_n > 0)
				sw_n <= sw_n - 1;
			if (halt_exec)
				halt_n <= halt_n + 1;
			if (stop_exec) begin
				stop_n   <= stop_n + 1;
				stop_cyc <= cyc;
			end
			if (ack_q) begin
				ack_q <= 1'b0;
				cnt_q <= 2'b00;
			end else if ((req.wr || req.rd) && cnt_q != lat) begin
				cnt_q <= cnt_q + 2'b01;
			end else if (req.rd) begin
				ack_q <= 1'b1;
				rd_q  <= rd_val(req.addr);
			end else if (req.wr) begin
				ack_q        <= 1'b1;
				log_a[log_n] <= req.addr;
				log_d[log_n] <= req.wdata;
				log_s[log_n] <= osc_stab_time_status_q;
				log_c[log_n] <= cyc;
				log_n        <= log_n + 1;
				case (req.addr)
					clk_switch_pkg::ADDR_CMC: begin
						if (!cmc_lk_q && req.byte8) begin
							cmc_q    <= req.wdata;
							cmc_lk_q <= 1'b1;
						end
					end
					clk_switch_pkg::ADDR_CSC: begin
						csc_q <= req.wdata;
						if (csc_q[7] && !req.wdata[7])
							osc_stab_time_status_q <= 8'h00;
					end
					clk_switch_pkg::ADDR_OSC_STAB_TIME_SELECT: osc_stab_time_select_q <= req.wdata;
					clk_switch_pkg::ADDR_CKC: begin
						css_q <= req.wdata[clk_switch_pkg::CKC_CSS_POS];
						mcm_q <= req.wdata[clk_switch_pkg::CKC_MCM_POS];
						sw_n  <= SW_DLY;
					end
					clk_switch_pkg::ADDR_OPERATION_SPEED_MODE_REG: begin
						if (!operation_speed_mode_reg_lk_q && req.byte8) begin
							operation_speed_mode_reg_q    <= req.wdata;
							operation_speed_mode_reg_lk_q <= 1'b1;
						end
					end
					default: ;
				endcase
			end
		end
	end
endmodule

/* verification/tb.sv */
// Self-checking bench for the clock source switch controller.
// Assumes the device model logs every write with its cycle.
`timescale 1ns/10ps
module tb;
	// ****************
	// Wiring and clock
	// ****************
	logic                     clk_sys, rst_n, cmd_valid, sfr_ack;
	clk_switch_pkg::cmd_t     cmd;
	logic [7:0]               sfr_rdata;
	clk_switch_pkg::sfr_req_t sfr_req;
	logic                     halt_exec, stop_exec, cmd_ready, cmd_done;
	logic                     cpu_on_sub, main_on_hs;
	logic [1:0]               lat;
	logic                     ext;
	int                       errors, total_checks, cyc_n, s, t0, i, j;

	initial clk_sys = 1'b0;
	always #50 clk_sys = ~clk_sys;

	clk_switch_ctrl #(.SUB_STAB_US(2)) dut_u (
		.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd(cmd), .sfr_ack(sfr_ack), .sfr_rdata(sfr_rdata),
		.sfr_req(sfr_req), .halt_exec(halt_exec), .stop_exec(stop_exec),
		.cmd_ready(cmd_ready), .cmd_done(cmd_done),
		.cpu_on_sub(cpu_on_sub), .main_on_hs(main_on_hs));
	clock_device_model dev_u (
		.clk_sys(clk_sys), .rst_n(rst_n), .req(sfr_req), .lat(lat),
		.halt_exec(halt_exec), .stop_exec(stop_exec),
		.sfr_ack(sfr_ack), .sfr_rdata(sfr_rdata));

	// ****************
	// Checks and helpers
	// ****************
	task chk_byte(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task stop_test;
		$display("Checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Index of first or last logged write to an address, -1 if none
	function automatic int find_wr(input logic [7:0] a, input int from,
		input bit last);
		int r;
		r = -1;
		for (int k = from; k < dev_u.log_n; k++) begin
			if (dev_u.log_a[k] == a && (last || r < 0))
				r = k;
		end
		return r;
	endfunction

	task run(input clk_switch_pkg::target_t tg, input logic fast,
		input logic [2:0] ss, input logic [7:0] need);
		int n;
		n = 0;
		s = dev_u.log_n;
		cmd = '{tg, ext, fast, fast, 1'b1, 1'b1, ss, need};
		chk_bit(cmd_ready, 1'b1);
		cmd_valid = 1'b1;
		@(posedge clk_sys);
		#2;
		t0 = dev_u.cyc;
		cmd_valid = 1'b0;
		chk_bit(cmd_ready, 1'b0);
		while (cmd_done !== 1'b1 && n < 3000) begin
			@(posedge clk_sys);
			#2;
			n++;
		end
		chk_bit(cmd_done, 1'b1);
	endtask

	// Hang guard, far above the few hundred cycles used
	always @(posedge clk_sys) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			errors++;
			stop_test();
		end
	end

	// ****************
	// Scenarios
	// ****************
	initial begin
		{rst_n, cmd_valid, lat, ext} = '0;
		cmd = '0;
		{errors, total_checks, cyc_n} = '0;
		repeat (12) @(posedge clk_sys);
		#2;
		rst_n = 1'b1;
		// Internal to fast crystal
		run(clk_switch_pkg::TGT_HS, 1'b1, 3'h4, 8'h30);
		i = find_wr(clk_switch_pkg::ADDR_CMC, s, 0);
		j = find_wr(clk_switch_pkg::ADDR_CKC, s, 0);
		chk_byte(dev_u.log_d[i] & 8'hd1, 8'h51);
		chk_byte(dev_u.log_d[find_wr(clk_switch_pkg::ADDR_OSC_STAB_TIME_SELECT, s, 0)], 8'h04);
		chk_bit(dev_u.log_d[find_wr(clk_switch_pkg::ADDR_CSC, s, 0)][7], 1'b0);
		chk_bit(dev_u.log_d[find_wr(clk_switch_pkg::ADDR_OPERATION_SPEED_MODE_REG, s, 0)][0], 1'b1);
		chk_bit(dev_u.log_s[j] >= 8'h30, 1'b1);
		chk_bit(dev_u.log_d[j][4], 1'b1);
		chk_bit(i >= 0 && i < j, 1'b1);
		chk_bit(dev_u.cyc - dev_u.log_c[j] >= 4, 1'b1);
		chk_bit(main_on_hs, 1'b1);
		chk_bit(cpu_on_sub, 1'b0);
		// Stop on crystal reprograms the settling select first
		run(clk_switch_pkg::TGT_STOP, 1'b1, 3'h6, 8'h00);
		j = find_wr(clk_switch_pkg::ADDR_OSC_STAB_TIME_SELECT, s, 1);
		chk_byte(dev_u.log_d[j], 8'h06);
		chk_bit(j >= 0 && dev_u.log_c[j] < dev_u.stop_cyc, 1'b1);
		chk_bit(dev_u.stop_n == 1, 1'b1);
		// Crystal to internal with a slow device
		lat = 2'd2;
		run(clk_switch_pkg::TGT_INT, 1'b0, 3'h6, 8'h00);
		j = find_wr(clk_switch_pkg::ADDR_CKC, s, 1);
		chk_bit(dev_u.log_d[j][4], 1'b0);
		chk_bit(dev_u.log_c[j] - t0 >= clk_switch_pkg::ACC_STAB_CYC, 1'b1);
		chk_bit(main_on_hs, 1'b0);
		lat = 2'd0;
		// Internal to subsystem, then repeat and halt there
		run(clk_switch_pkg::TGT_SUB, 1'b0, 3'h6, 8'h00);
		i = find_wr(clk_switch_pkg::ADDR_CSC, s, 1);
		j = find_wr(clk_switch_pkg::ADDR_CKC, s, 1);
		chk_bit(dev_u.log_d[i][6], 1'b0);
		chk_bit(dev_u.log_d[j][6], 1'b1);
		chk_bit(i >= 0 && dev_u.log_c[j] - dev_u.log_c[i] >= 20, 1'b1);
		chk_bit(find_wr(clk_switch_pkg::ADDR_CMC, s, 0) < 0, 1'b1);
		chk_bit(cpu_on_sub, 1'b1);
		run(clk_switch_pkg::TGT_SUB, 1'b0, 3'h6, 8'h00);
		chk_bit(dev_u.log_n == s, 1'b1);
		run(clk_switch_pkg::TGT_HALT, 1'b0, 3'h6, 8'h00);
		chk_bit(dev_u.halt_n == 1, 1'b1);
		// Subsystem back to crystal, setup already in place
		run(clk_switch_pkg::TGT_HS, 1'b1, 3'h6, 8'h00);
		i = find_wr(clk_switch_pkg::ADDR_CKC, s, 0);
		j = find_wr(clk_switch_pkg::ADDR_CKC, s, 1);
		chk_byte(dev_u.log_d[i] & 8'h50, 8'h50);
		chk_byte(dev_u.log_d[j] & 8'h50, 8'h10);
		chk_bit(find_wr(clk_switch_pkg::ADDR_CSC, s, 0) < 0, 1'b1);
		chk_bit(find_wr(clk_switch_pkg::ADDR_OPERATION_SPEED_MODE_REG, s, 0) < 0, 1'b1);
		chk_bit(cpu_on_sub, 1'b0);
		// Crystal to subsystem, then subsystem to internal
		run(clk_switch_pkg::TGT_SUB, 1'b0, 3'h6, 8'h00);
		chk_bit(cpu_on_sub, 1'b1);
		run(clk_switch_pkg::TGT_INT, 1'b0, 3'h6, 8'h00);
		i = find_wr(clk_switch_pkg::ADDR_CKC, s, 0);
		j = find_wr(clk_switch_pkg::ADDR_CKC, s, 1);
		chk_byte(dev_u.log_d[i] & 8'h50, 8'h40);
		chk_byte(dev_u.log_d[j] & 8'h50, 8'h00);
		chk_bit(find_wr(clk_switch_pkg::ADDR_CSC, s, 0) < 0, 1'b1);
		chk_bit(main_on_hs, 1'b0);
		chk_bit(cpu_on_sub, 1'b0);
		// Second reset, then external clock: counter never polled
		rst_n = 1'b0;
		ext = 1'b1;
		@(posedge clk_sys);
		#2;
		rst_n = 1'b1;
		run(clk_switch_pkg::TGT_HS, 1'b0, 3'h6, 8'hff);
		i = find_wr(clk_switch_pkg::ADDR_CMC, s, 0);
		j = find_wr(clk_switch_pkg::ADDR_CKC, s, 0);
		chk_byte(dev_u.log_d[i] & 8'hd1, 8'hd0);
		chk_bit(j >= 0 && dev_u.log_c[j] - t0 < 100, 1'b1);
		chk_bit(main_on_hs, 1'b1);
		stop_test();
	end
endmodule
